// ==== common/mic_pkg.sv ====
package mic_pkg;

  // ****************************************************************
  // Register offsets, printed as indices; byte address is four times.
  // ****************************************************************
  localparam logic [7:0] MIC_IDX_ENABLE = 8'h0c;
  localparam logic [7:0] MIC_IDX_PEND   = 8'h0d;
  localparam logic [7:0] MIC_IDX_ROUTE  = 8'h0e;
  localparam logic [7:0] MIC_IDX_RATE   = 8'h0f;
  localparam logic [7:0] MIC_IDX_KEY    = 8'h14;
  localparam logic [7:0] MIC_IDX_MODE   = 8'h20;
  localparam logic [7:0] MIC_IDX_VECTOR = 8'h21;

  // ****************************************************************
  // Field layout and reset values.
  // ****************************************************************
  localparam int         MIC_NSRC          = 8;
  localparam logic [7:0] MIC_SRC_MASK      = 8'hbf;
  localparam int         MIC_BIT_T0        = 2;
  localparam int         MIC_BIT_EXT       = 5;
  localparam int         MIC_BIT_KEY       = 7;
  localparam int         MIC_BIT_EDGE      = 6;
  localparam int         MIC_BIT_KEYMODE   = 5;
  localparam logic [7:0] MIC_RST_ENABLE    = 8'h00;
  localparam logic [7:0] MIC_RST_PEND      = 8'h00;
  localparam logic [7:0] MIC_RST_ROUTE     = 8'h00;
  localparam logic [7:0] MIC_RST_RATE      = 8'h43;
  localparam logic [7:0] MIC_RST_KEY       = 8'h00;
  localparam logic [10:0] MIC_VEC_BASE     = 11'h7e0;
  localparam logic [2:0] MIC_FAST_TAP_BASE = 3'h0;
  localparam int         MIC_CHAIN_W       = 14;
  localparam int         MIC_FAST_LOW_TAP  = 10;
  localparam int         MIC_SLOW_LOW_TAP  = 13;

  // ****************************************************************
  // Operating modes and request state.
  // ****************************************************************
  typedef enum logic [1:0] {
    MIC_MODE_RUN     = 2'b00,
    MIC_MODE_STANDBY = 2'b01,
    MIC_MODE_HALT    = 2'b10
  } mic_mode_e;

  typedef enum logic [1:0] {
    MIC_BUS_IDLE = 2'b00,
    MIC_BUS_ACK  = 2'b01
  } mic_bus_e;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [9:0] address;
    logic [31:0] writedata;
  } mic_req_s;

  typedef struct packed {
    mic_bus_e   bus;
    logic [31:0] rdata;
    logic [7:0] enable;
    logic [7:0] pend;
    logic [7:0] route;
    logic [7:0] rate;
    logic [7:0] key;
    mic_mode_e  mode;
    logic [MIC_CHAIN_W-1:0] chain;
    logic       ext_prev;
    logic       irq;
    logic       nmi;
    logic [7:0] nmi_prev;
    logic [2:0] vec_idx;
    logic       wake;
  } mic_state_s;

endpackage : mic_pkg

// ==== rtl/mic_interrupt_controller.sv ====
// Notes on behaviour
// - Seven sources: three timers, ticks, pin, keys.
// - Event sets pending flag until written zero.
// - Flags set regardless of enables, for polling.
// - Enable bit positions fixed; all reset disabled.
// - Flags read in enable positions, reset zero.
// - Writing zero clears flag bits 0-5, 7.
// - Bit 2 serves timer0 stop when enabled.
// - Route bit one gives NMI, zero IRQ.
// - Fast tick rate field selects chain tap.
// - Slow tick rate field selects chain tap.
// - Rate bit 6 selects external pin edge.
// - Key bit 5 selects strobe or scan.
// - Tick chain runs except in halt mode.
// - Core pushes PC and jumps to vector.
// - Vectors 7E0..7EE, two apart, fixed priority.
// - IRQ level held until service finishes.
// - NMI edge sensed; coincident lower lost.
// - All events wake standby; pin, key halt.
//
// Added by the designer: the Avalon-MM slave port.
module mic_interrupt_controller
  import mic_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Event sources
  input  wire logic        timer2_event_in,
  input  wire logic        timer1_event_in,
  input  wire logic        timer0_event_in,
  input  wire logic        timer0_stop_event_in,
  input  wire logic        timer0_stop_enable_in,
  input  wire logic        ext_irq_pin_in,
  input  wire logic        key_strobe_in,
  input  wire logic        key_scan_done_in,
  input  wire logic        key_change_in,
  input  wire logic        slow_clk_tick_in,
  // Core side
  input  wire logic        sleep_enter_in,
  input  wire logic        rtc_enable_in,
  input  wire logic        irq_ack_in,
  output logic             irq_out,
  output logic             nmi_out,
  output logic      [10:0] vector_out,
  output logic             wake_out
);

  // ****************************************************************
  // State.
  // ****************************************************************
  mic_state_s q;
  mic_state_s d;

  logic [7:0] raw_ev;
  logic [7:0] pend_next;
  logic [7:0] irq_cand;
  logic [7:0] nmi_cand;
  logic [7:0] nmi_new;
  logic [7:0] pend_set;
  logic [7:0] pend_clr;
  logic       pend_wr;
  logic       take;
  logic       wake_standby;
  logic       wake_halt;
  logic [2:0] irq_sel;
  logic       irq_any;
  logic [2:0] nmi_sel;
  logic       nmi_rise;
  logic       fast_tap;
  logic       slow_tap;
  logic       fast_prev_q;
  logic       slow_prev_q;
  logic       fast_ev;
  logic       slow_ev;
  logic       ext_ev;
  logic       key_ev;
  logic       t0_ev;
  logic       hit;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [3:0] fsel;
  logic [3:0] ssel;

  // ****************************************************************
  // Elaboration checks.
  // ****************************************************************
  if (MIC_NSRC != 8)
  begin : g_check_nsrc
    $error("The flag, enable and route registers are one byte wide.");
  end

  if (MIC_SLOW_LOW_TAP >= MIC_CHAIN_W)
  begin : g_check_slow_top
    $error("The slowest tick tap lies beyond the divider chain.");
  end

  if (MIC_SLOW_LOW_TAP < 7)
  begin : g_check_slow_low
    $error("The fastest slow tick tap would fall below the chain.");
  end

  if (MIC_FAST_LOW_TAP < 10 || MIC_FAST_LOW_TAP >= MIC_CHAIN_W)
  begin : g_check_fast
    $error("The fast tick taps do not fit the divider chain.");
  end

  if (MIC_SRC_MASK[6] != 1'b0)
  begin : g_check_mask
    $error("Bit 6 carries no source and must stay masked.");
  end

  if (MIC_VEC_BASE[3:0] != 4'h0)
  begin : g_check_vec
    $error("The vector base must leave room for eight two-byte slots.");
  end

  // ****************************************************************
  // Event detection.
  // ****************************************************************
  // The fast taps step by two chain stages for the four slow codes and by
  // one stage for the four fast codes.
  always_comb
  begin
    case (q.rate[2:0])
      3'h0:    fsel = 4'(MIC_FAST_LOW_TAP);
      3'h1:    fsel = 4'(MIC_FAST_LOW_TAP - 2);
      3'h2:    fsel = 4'(MIC_FAST_LOW_TAP - 4);
      3'h3:    fsel = 4'(MIC_FAST_LOW_TAP - 6);
      3'h4:    fsel = 4'(MIC_FAST_LOW_TAP - 7);
      3'h5:    fsel = 4'(MIC_FAST_LOW_TAP - 8);
      3'h6:    fsel = 4'(MIC_FAST_LOW_TAP - 9);
      3'h7:    fsel = 4'(MIC_FAST_LOW_TAP - 10);
      default: fsel = 4'(MIC_FAST_LOW_TAP);
    endcase
  end
  assign ssel     = 4'(MIC_SLOW_LOW_TAP) - 4'(q.rate[5:3]);
  assign fast_tap = q.chain[fsel];
  assign slow_tap = q.chain[ssel];
  assign fast_ev  = fast_tap & ~fast_prev_q;
  assign slow_ev  = slow_tap & ~slow_prev_q;
  assign ext_ev   = q.rate[MIC_BIT_EDGE] ? (ext_irq_pin_in & ~q.ext_prev)
                                         : (~ext_irq_pin_in & q.ext_prev);
  assign key_ev   = q.key[MIC_BIT_KEYMODE] ? key_scan_done_in : key_strobe_in;
  assign t0_ev    = timer0_stop_enable_in ? timer0_stop_event_in : timer0_event_in;

  assign raw_ev = {key_ev, 1'b0, ext_ev, slow_ev, fast_ev, t0_ev,
                   timer1_event_in, timer2_event_in};

  // Standby keeps the slow clock, so every source wakes it; halt stops the
  // divider chain and only the pin and a key change can end it.
  assign wake_standby = (|raw_ev) | key_change_in;
  assign wake_halt    = ext_ev | key_change_in;

  // ****************************************************************
  // Per-source flag and request logic.
  // ****************************************************************
  // Bit 6 has no source; the mask keeps its flag and requests at zero.
  for (genvar gi = 0; gi < MIC_NSRC; gi++)
  begin : g_src
    // A set in the same cycle as a written clear wins over the clear.
    assign pend_set[gi]  = raw_ev[gi] & MIC_SRC_MASK[gi];
    assign pend_clr[gi]  = pend_wr & ~wbyte[gi];
    assign pend_next[gi] = MIC_SRC_MASK[gi] & (pend_set[gi] | (q.pend[gi] & ~pend_clr[gi]));
    assign irq_cand[gi]  = q.pend[gi] & q.enable[gi] & ~q.route[gi] & MIC_SRC_MASK[gi];
    assign nmi_cand[gi]  = q.pend[gi] & q.enable[gi] & q.route[gi] & MIC_SRC_MASK[gi];
    // A routed source requests once per rise of its candidate, not per cycle.
    assign nmi_new[gi]   = nmi_cand[gi] & ~q.nmi_prev[gi];
  end

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  assign idx   = 8'(avs_address_in[9:2]);
  assign wbyte = avs_byteenable_in[0] ? avs_writedata_in[7:0] : 8'hff;
  assign take  = (avs_read_in | avs_write_in) & (q.bus == MIC_BUS_IDLE);
  // A write lands on the edge at which waitrequest is sampled low, so no
  // register changes before the master's own transfer completes.
  assign hit   = (q.bus == MIC_BUS_ACK) & avs_write_in & avs_byteenable_in[0];
  assign pend_wr = hit & (idx == MIC_IDX_PEND);

  always_comb
  begin
    case (idx)
      MIC_IDX_ENABLE: rbyte = q.enable;
      MIC_IDX_PEND:   rbyte = q.pend;
      MIC_IDX_ROUTE:  rbyte = q.route;
      MIC_IDX_RATE:   rbyte = q.rate;
      MIC_IDX_KEY:    rbyte = q.key;
      MIC_IDX_MODE:   rbyte = {6'h00, q.mode};
      MIC_IDX_VECTOR: rbyte = {5'h00, q.vec_idx};
      default:        rbyte = 8'h00;
    endcase
  end

  // ****************************************************************
  // Priority selection, lowest bit highest.
  // ****************************************************************
  always_comb
  begin
    irq_sel  = 3'h0;
    irq_any  = 1'b0;
    nmi_sel  = 3'h0;
    for (int i = MIC_NSRC - 1; i >= 0; i--)
    begin
      if (irq_cand[i])
      begin
        irq_sel = 3'(i);
        irq_any = 1'b1;
      end
      if (nmi_new[i])
      begin
        nmi_sel = 3'(i);
      end
    end
    nmi_rise = |nmi_new;
  end

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb
  begin
    d           = q;
    d.bus       = MIC_BUS_IDLE;
    d.ext_prev  = ext_irq_pin_in;
    d.nmi_prev  = nmi_cand;
    // Read data is captured when the request is taken and stands until the
    // next access, so it is valid while waitrequest is low.
    if (take)
    begin
      d.bus   = MIC_BUS_ACK;
      d.rdata = {24'h00_0000, rbyte};
    end
    if (hit)
    begin
      case (idx)
        MIC_IDX_ENABLE: d.enable = wbyte & MIC_SRC_MASK;
        MIC_IDX_ROUTE:  d.route = wbyte & MIC_SRC_MASK;
        MIC_IDX_RATE:   d.rate = {1'b0, wbyte[6:0]};
        MIC_IDX_KEY:    d.key = wbyte & 8'h20;
        default:        d.rate = d.rate;
      endcase
    end
    d.pend      = pend_next;
    if (q.mode != MIC_MODE_HALT)
    begin
      if (slow_clk_tick_in)
      begin
        d.chain = q.chain + 14'h0001;
      end
    end
    // IRQ level request holds while any enabled flag routed to IRQ stays pending.
    d.irq = irq_any;
    if (irq_any & ~irq_ack_in)
    begin
      d.vec_idx = irq_sel;
    end
    d.nmi = nmi_rise;
    if (nmi_rise)
    begin
      d.vec_idx = nmi_sel;
    end
    d.wake = 1'b0;
    case (q.mode)
      MIC_MODE_RUN:
      begin
        if (sleep_enter_in)
        begin
          d.mode = rtc_enable_in ? MIC_MODE_STANDBY : MIC_MODE_HALT;
        end
      end
      MIC_MODE_STANDBY:
      begin
        if (wake_standby)
        begin
          d.mode = MIC_MODE_RUN;
          d.wake = 1'b1;
        end
      end
      MIC_MODE_HALT:
      begin
        if (wake_halt)
        begin
          d.mode = MIC_MODE_RUN;
          d.wake = 1'b1;
        end
      end
      default: d.mode = MIC_MODE_RUN;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q.bus      <= MIC_BUS_IDLE;
      q.rdata    <= 32'h0000_0000;
      q.enable   <= MIC_RST_ENABLE;
      q.pend     <= MIC_RST_PEND;
      q.route    <= MIC_RST_ROUTE;
      q.rate     <= MIC_RST_RATE;
      q.key      <= MIC_RST_KEY;
      q.mode     <= MIC_MODE_RUN;
      q.chain    <= '0;
      q.ext_prev <= 1'b0;
      q.irq      <= 1'b0;
      q.nmi      <= 1'b0;
      q.nmi_prev <= 8'h00;
      q.vec_idx  <= 3'h0;
      q.wake     <= 1'b0;
      fast_prev_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end
    else
    begin
      q           <= d;
      fast_prev_q <= fast_tap;
      slow_prev_q <= slow_tap;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  always_comb
  begin
    avs_readdata_out    = q.rdata;
    avs_waitrequest_out = ~((q.bus == MIC_BUS_ACK) | ~(avs_read_in | avs_write_in));
    irq_out             = q.irq;
    nmi_out             = q.nmi;
    vector_out          = MIC_VEC_BASE + {7'h00, q.vec_idx, 1'b0};
    wake_out            = q.wake;
  end

endmodule : mic_interrupt_controller

// ==== sim/mic_monitor.sv ====
module mic_monitor
  import mic_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic        irq_ack_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        nmi_out,
  input wire logic [10:0] vector_out,
  input wire logic        wake_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  AST_WAIT_FIRST: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("no wait on first cycle");
  AST_WAIT_ONE: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("wait too long");
  AST_WAIT_IDLE: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("wait while idle");
  AST_READ_UPPER: assert property (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_NMI_PULSE: assert property (nmi_out |=> !nmi_out)
    else $error("nmi too long");
  AST_WAKE_PULSE: assert property (wake_out |=> !wake_out)
    else $error("wake too long");
  AST_VEC_RANGE: assert property (vector_out[10:4] == 7'h7e && !vector_out[0])
    else $error("vector out of range");
  AST_VEC_FREEZE: assert property ($past(irq_ack_in, 2) && $past(irq_ack_in) && irq_ack_in
    |-> $stable(vector_out)) else $error("vector moved in ack");
endmodule : mic_monitor

bind mic_interrupt_controller mic_monitor i_mon (.core_clk_in, .rst_n_in, .avs_read_in,
  .avs_write_in, .irq_ack_in, .avs_readdata_out, .avs_waitrequest_out, .nmi_out, .vector_out,
  .wake_out);

// ==== sim/mic_core_model.sv ====
module mic_core_model
  import mic_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        irq_in,
  input  wire logic [10:0] vector_in,
  input  wire logic        rti_in,
  output logic             irq_ack_out,
  output logic             taken_out,
  output logic      [10:0] taken_vec_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    irq_ack_out = 1'b0;
    taken_out = 1'b0;
    taken_vec_out = 11'h000;
  end
  // A level request is taken after a varying latency and held until return.
  always @(posedge clk_in)
  begin
    if (rst_n_in && irq_in === 1'b1)
    begin
      repeat ($urandom_range(4, 1)) @(posedge clk_in);
      irq_ack_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      taken_vec_out <= vector_in;
      taken_out <= 1'b1;
      @(posedge clk_in);
      taken_out <= 1'b0;
      while (rti_in !== 1'b1) @(posedge clk_in);
      irq_ack_out <= 1'b0;
    end
  end
endmodule : mic_core_model

// ==== sim/mic_interrupt_controller_bench.sv ====
module mic_interrupt_controller_bench
  import mic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, t0se = 0, pin = 0, tick = 0, rti = 0, rtce = 0;
  logic irq, nmi, wake, wtr, ack, taken;
  logic [7:0] src = 8'h00;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [10:0] vec, tvec;
  logic [7:0] rq[$];
  logic [10:0] vq[$];
  int fails = 0, num_checks = 0, nmi_n = 0, wake_n = 0;
  logic [7:0] ri [6] = '{MIC_IDX_ENABLE, MIC_IDX_PEND, MIC_IDX_ROUTE, MIC_IDX_RATE, MIC_IDX_KEY, 8'h30};
  logic [7:0] re [6] = '{8'h00, 8'h00, 8'h00, 8'h43, 8'h00, 8'h00};

  always #25 clk = ~clk;

  mic_interrupt_controller i_dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wtr), .timer2_event_in(src[0]),
    .timer1_event_in(src[1]), .timer0_event_in(src[2]), .timer0_stop_event_in(src[6]),
    .timer0_stop_enable_in(t0se), .ext_irq_pin_in(pin), .key_strobe_in(src[7]),
    .key_scan_done_in(src[5]), .key_change_in(src[4]), .slow_clk_tick_in(tick),
    .sleep_enter_in(src[3]), .rtc_enable_in(rtce), .irq_ack_in(ack), .irq_out(irq),
    .nmi_out(nmi), .vector_out(vec), .wake_out(wake));
  mic_core_model i_core (.clk_in(clk), .rst_n_in(rst_n), .irq_in(irq), .vector_in(vec),
    .rti_in(rti), .irq_ack_out(ack), .taken_out(taken), .taken_vec_out(tvec));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic chk_rd(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin fails++; $display("[FAIL] %s expected %h seen %h", what, e, g); end
  endtask : chk_rd

  task automatic chk_vec(input string what, input logic [10:0] e, input logic [10:0] g);
    num_checks++;
    if (g !== e) begin fails++; $display("[FAIL] %s expected %h seen %h", what, e, g); end
  endtask : chk_vec

  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wtr !== 1'b0 && n < 20);
    if (wtr !== 1'b0) begin fails++; wrap_up(); end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc

  task automatic peek(input logic [7:0] idx, input logic [7:0] e);
    rq.push_back(e);
    acc(1'b0, idx, 8'h00);
  endtask : peek

  task automatic fire(input logic [7:0] m);
    @(posedge clk);
    src <= m;
    @(posedge clk);
    src <= 8'h00;
  endtask : fire

  task automatic serve(input int left, input logic [7:0] clr);
    int n;
    for (n = 0; n < 400 && vq.size() > left; n++) @(posedge clk);
    if (n == 400) begin fails++; wrap_up(); end
    tick <= 1'b0;
    acc(1'b1, MIC_IDX_PEND, clr);
    repeat (2) @(posedge clk);
    rti <= 1'b1;
    @(posedge clk);
    rti <= 1'b0;
  endtask : serve

  always @(negedge clk)
  begin
    if (rd && wtr === 1'b0) chk_rd("readdata", {24'h0, rq.pop_front()}, rdata);
    if (taken === 1'b1) chk_vec("vector", vq.pop_front(), tvec);
    if (nmi === 1'b1) nmi_n++;
    if (wake === 1'b1) wake_n++;
  end

  initial
  begin
    int i, b, n;
    logic [7:0] d;
    d = 8'($urandom(32'h226f_4f59));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) peek(ri[i], re[i]);
    d = 8'($urandom);
    acc(1'b1, MIC_IDX_ENABLE, d);
    peek(MIC_IDX_ENABLE, d & 8'hbf);
    acc(1'b1, MIC_IDX_ROUTE, ~d);
    peek(MIC_IDX_ROUTE, ~d & 8'hbf);
    acc(1'b1, MIC_IDX_ENABLE, 8'h00);
    acc(1'b1, MIC_IDX_ROUTE, 8'h00);
    fire(8'h02);
    peek(MIC_IDX_PEND, 8'h02);
    acc(1'b1, MIC_IDX_PEND, 8'hff);
    peek(MIC_IDX_PEND, 8'h02);
    acc(1'b1, MIC_IDX_PEND, 8'hfd);
    peek(MIC_IDX_PEND, 8'h00);
    acc(1'b1, MIC_IDX_RATE, 8'h7f);
    for (i = 0; i < 8; i++)
    begin
      b = (i == 6) ? 2 : i;
      t0se <= (i == 6);
      acc(1'b1, MIC_IDX_ENABLE, 8'h01 << b);
      vq.push_back(11'h7e0 + 11'(2 * b));
      if (i == 5) pin <= 1'b1;
      else if (i == 3 || i == 4) tick <= 1'b1;
      else fire(8'h01 << i);
      serve(0, 8'h00);
    end
    acc(1'b1, MIC_IDX_ENABLE, 8'h05);
    vq.push_back(11'h7e0);
    vq.push_back(11'h7e4);
    fire(8'h05);
    serve(1, 8'hfe);
    serve(0, 8'hfb);
    acc(1'b1, MIC_IDX_ENABLE, 8'h03);
    acc(1'b1, MIC_IDX_ROUTE, 8'h03);
    n = nmi_n;
    fire(8'h03);
    repeat (4) @(posedge clk);
    chk_rd("nmi pulses", 1, nmi_n - n);
    acc(1'b1, MIC_IDX_PEND, 8'h00);
    acc(1'b1, MIC_IDX_ENABLE, 8'h00);
    acc(1'b1, MIC_IDX_ROUTE, 8'h00);
    acc(1'b1, MIC_IDX_RATE, 8'h3f);
    pin <= 1'b0;
    peek(MIC_IDX_PEND, 8'h20);
    acc(1'b1, MIC_IDX_PEND, 8'h00);
    acc(1'b1, MIC_IDX_KEY, 8'h20);
    fire(8'h80);
    peek(MIC_IDX_PEND, 8'h00);
    fire(8'h20);
    peek(MIC_IDX_PEND, 8'h80);
    n = wake_n;
    fire(8'h08);
    fire(8'h02);
    repeat (3) @(posedge clk);
    chk_rd("wakes", n, wake_n);
    peek(MIC_IDX_MODE, 8'h02);
    fire(8'h10);
    repeat (3) @(posedge clk);
    chk_rd("wakes", n + 1, wake_n);
    peek(MIC_IDX_MODE, 8'h00);
    rtce <= 1'b1;
    fire(8'h08);
    peek(MIC_IDX_MODE, 8'h01);
    fire(8'h02);
    repeat (3) @(posedge clk);
    chk_rd("wakes", n + 2, wake_n);
    wrap_up();
  end
endmodule : mic_interrupt_controller_bench
